// ---- include/twl_pkg.sv ----
// package: constants, a decode function and register map of the thermal watch link
// Summary of operation
// RULE1: reading stored as 11-bit signed, 0.125 degree steps
// RULE2: reading D10..D3 high byte, D2..D0 low
// RULE3: reading register read-only, refreshed per conversion
// RULE4: reading transfers two bytes, high byte first
// RULE5: single high-byte read allowed, bus stays clean
// RULE6: controller treats D10 set as negative
// RULE7: legacy controller may use top nine bits
// RULE8: over-heat and hysteresis limits, 9-bit signed
// RULE9: limit D8..D1 high byte, D0 bit7 low
// RULE10: limit reads send sixteen bits, both collected
// RULE11: compare top nine reading bits with limits
// RULE12: polarity bit B2, 1 high, reset 0
// RULE13: mode bit B1, 1 interrupt, reset comparator
// RULE14: comparator: set above over-heat, clear below hysteresis
// RULE15: comparator: reads and shutdown leave alarm
// RULE16: interrupt: latch on event, clear on read
// RULE17: controller keeps over-heat above hysteresis
// RULE18: alarm pin open-drain, only pulls low
// RULE19: fault queue 1,2,4,6 consecutive conversions
// RULE20: shutdown stops conversions, clears interrupt alarm
// RULE21: limits reset to 5000h and 4B00h
// RULE22: selector 00 reading,01 config,10 hyst,11 over
// RULE23: interrupt mode alternates over-heat and hysteresis arming
package twl_pkg;
    // register selector codes
    localparam logic [1:0] SEL_READING = 2'h0; // RULE22
    localparam logic [1:0] SEL_CONFIG = 2'h1;
    localparam logic [1:0] SEL_HYST = 2'h2;
    localparam logic [1:0] SEL_OVER = 2'h3;
    // reset values
    localparam logic [15:0] OVER_RST = 16'h5000; // RULE21
    localparam logic [15:0] HYST_RST = 16'h4B00;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    // configuration bit positions
    localparam int CFG_SHUT = 0;
    localparam int CFG_MODE = 1;
    localparam int CFG_POL = 2;
    localparam int CFG_QLO = 3;
    localparam int CFG_QHI = 4;
    // controller command port offsets
    localparam logic [3:0] CMD_CTRL = 4'h0; // w: bit0 go, bit1 write, [3:2] sel, bit4 one byte
    localparam logic [3:0] CMD_WDATA = 4'h1;
    localparam logic [3:0] CMD_STATUS = 4'h2; // r: bit0 busy
    localparam logic [3:0] CMD_RDATA = 4'h3;
    localparam logic [3:0] CMD_DIV = 4'h4; // link phase length minus one, in cycles; scl high one phase, low two
    localparam logic [7:0] DIV_RST = 8'h0A;
    // conversion period in cycles (parameter default on the device)
    localparam int CONV_CYCLES = 64;
    localparam int TEMP_W = 11;
    localparam int LIM_W = 9;

    // decode an alarm fault count setting into needed conversions
    function automatic logic [2:0] twl_queue_len(input logic [1:0] q);
        case (q)
            2'h0: twl_queue_len = 3'h1; // RULE19
            2'h1: twl_queue_len = 3'h2;
            2'h2: twl_queue_len = 3'h4;
            default: twl_queue_len = 3'h6;
        endcase
    endfunction
endpackage

// ---- include/twl_if.sv ----
// interface: serial register link between controller and thermal watch device
`timescale 1ns/100ps
interface twl_if;
    logic scl; // serial clock, driven by controller
    logic sda_m_o; // controller data out
    logic sda_m_oe_n; // controller drive enable, low drives
    logic sda_s_o; // device data out
    logic sda_s_oe_n; // device drive enable, low drives
    logic sda; // resolved wire level, pulled up
    assign sda = ((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o)) ? 1'b0 : 1'b1;
    modport dev (input scl, input sda, output sda_s_o, output sda_s_oe_n);
    modport ctl (output scl, input sda, output sda_m_o, output sda_m_oe_n);
endinterface

// ---- core/twl_device.sv ----
// module: thermal watch device with register link, limits and alarm logic
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
module twl_device
    import twl_pkg::*;
#(
    parameter int CONV_PERIOD = twl_pkg::CONV_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    twl_if.dev link,
    input wire logic [10:0] adc_result_i,
    output logic alarm_output_o,
    output logic alarm_output_oe_n_o,
    output logic [7:0] config_o
);
    import twl_pkg::*;

    typedef enum logic [1:0] {
        TWD_IDLE = 2'b00,
        TWD_SHIFT = 2'b01,
        TWD_ACK = 2'b11,
        TWD_SEND = 2'b10
    } twd_state_e;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        twd_state_e st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [1:0] bytn;
        logic wr;
        logic [1:0] sel;
        logic [15:0] txw;
        logic sdo;
        logic [10:0] reading;
        logic [8:0] over_lim;
        logic [8:0] hyst_lim;
        logic [7:0] cfg;
        logic [15:0] conv_cnt;
        logic [2:0] fault_cnt;
        logic active;
        logic arm_low;
        logic alarm;
    } twd_s;

    twd_s q, d;
    logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
    logic conv_done, hot, cold, fault, reg_read;
    logic [8:0] top9;

    // link pins pass two flops before any use
    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[0], link.scl};
        d.sda_s = {q.sda_s[0], link.sda};
        scl = q.scl_s[1];
        sda = q.sda_s[1];
        d.scl_p = scl;
        d.sda_p = sda;
        scl_rise = scl && !q.scl_p;
        scl_fall = !scl && q.scl_p;
        start_c = scl && q.scl_p && q.sda_p && !sda;
        stop_c = scl && q.scl_p && !q.sda_p && sda;
        reg_read = 1'b0;

        // ---------------------------------------------------------------
        // serial protocol: address, selector, data bytes
        // ---------------------------------------------------------------
        case (q.st)
            TWD_IDLE: begin
                d.sdo = 1'b1;
            end
            TWD_SHIFT: begin
                if (scl_rise) begin
                    d.sh = {q.sh[6:0], sda};
                    d.bitn = q.bitn + 4'h1;
                end
                if (scl_fall && q.bitn == 4'h8) begin
                    d.bitn = 4'h0;
                    d.st = TWD_ACK;
                    d.sdo = 1'b0;
                    if (q.bytn == 2'h0) begin
                        d.wr = !q.sh[0];
                        if (q.sh[0]) begin
                            d.sdo = 1'b0;
                        end
                    end else if (q.bytn == 2'h1) begin
                        d.sel = q.sh[1:0]; // RULE22
                    end else if (q.sel == SEL_CONFIG) begin
                        d.cfg = q.sh;
                    end else if (q.sel == SEL_OVER) begin
                        if (q.bytn == 2'h2) d.over_lim[8:1] = q.sh; // RULE8
                        else d.over_lim[0] = q.sh[7]; // RULE9
                    end else if (q.sel == SEL_HYST) begin
                        if (q.bytn == 2'h2) d.hyst_lim[8:1] = q.sh;
                        else d.hyst_lim[0] = q.sh[7];
                    end
                end
            end
            TWD_ACK: begin
                if (scl_fall) begin
                    d.sdo = 1'b1;
                    d.bytn = (q.bytn == 2'h3) ? 2'h3 : q.bytn + 2'h1;
                    if (q.bytn == 2'h0 && !q.wr) begin
                        // read: load the selected register, high byte first
                        case (q.sel)
                            SEL_READING: d.txw = {q.reading, 5'h00}; // RULE2 RULE4
                            SEL_CONFIG: d.txw = {q.cfg, q.cfg};
                            SEL_HYST: d.txw = {q.hyst_lim, 7'h00}; // RULE9 RULE10
                            default: d.txw = {q.over_lim, 7'h00};
                        endcase
                        reg_read = 1'b1; // RULE16
                        d.sdo = d.txw[15];
                        d.st = TWD_SEND;
                    end else begin
                        d.st = TWD_SHIFT;
                    end
                end
            end
            TWD_SEND: begin
                if (scl_rise && q.bitn == 4'h8 && sda) begin
                    d.st = TWD_IDLE; // RULE5 nack ends transfer cleanly
                end
                if (scl_fall) begin
                    if (q.bitn == 4'h7) begin
                        d.sdo = 1'b1;
                        d.bitn = 4'h8;
                    end else if (q.bitn == 4'h8) begin
                        // after the master ack: next bit was held one place down
                        d.bitn = 4'h0;
                        d.txw = {q.txw[14:0], 1'b0};
                        d.sdo = q.txw[14];
                    end else begin
                        d.txw = {q.txw[14:0], 1'b0};
                        d.sdo = q.txw[14];
                        d.bitn = q.bitn + 4'h1;
                    end
                end
            end
            default: d.st = TWD_IDLE;
        endcase
        if (start_c) begin
            d.st = TWD_SHIFT;
            d.bitn = 4'h0;
            d.bytn = 2'h0;
            d.sdo = 1'b1;
        end
        if (stop_c) begin
            d.st = TWD_IDLE;
            d.sdo = 1'b1;
        end

        // ---------------------------------------------------------------
        // conversion timer and alarm decision
        // ---------------------------------------------------------------
        conv_done = 1'b0;
        if (!q.cfg[CFG_SHUT]) begin
            if (q.conv_cnt >= 16'(CONV_PERIOD - 1)) begin
                d.conv_cnt = 16'h0000;
                conv_done = 1'b1;
            end else begin
                d.conv_cnt = q.conv_cnt + 16'h0001;
            end
        end
        if (conv_done) d.reading = adc_result_i; // RULE1 RULE3
        // judge the result just taken, not the one from the conversion before
        top9 = d.reading[10:2]; // RULE11
        hot = $signed(top9) > $signed(q.over_lim);
        cold = $signed(top9) < $signed(q.hyst_lim);
        // interrupt mode watches one side at a time; comparator watches the
        // side opposite the current state
        if (q.cfg[CFG_MODE]) fault = q.arm_low ? cold : hot; // RULE23
        else fault = q.active ? cold : hot; // RULE14
        if (conv_done) begin
            if (!fault) begin
                d.fault_cnt = 3'h0;
            end else if (q.fault_cnt + 3'h1 >= twl_queue_len(q.cfg[CFG_QHI:CFG_QLO])) begin
                d.fault_cnt = 3'h0; // RULE19
                if (q.cfg[CFG_MODE]) begin
                    d.active = 1'b1; // RULE16
                    d.arm_low = !q.arm_low; // RULE23
                end else begin
                    d.active = !q.active;
                end
            end else begin
                d.fault_cnt = q.fault_cnt + 3'h1;
            end
        end
        // read clears only in interrupt mode; a fresh event wins over clear
        if (q.cfg[CFG_MODE] && reg_read && !(conv_done && fault)) d.active = 1'b0; // RULE15 RULE16
        if (q.cfg[CFG_MODE] && d.cfg[CFG_SHUT] && !q.cfg[CFG_SHUT]) d.active = 1'b0; // RULE20
        // pin level: active state follows polarity
        d.alarm = d.active ~^ d.cfg[CFG_POL]; // RULE12 RULE13
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            q <= '0;
            q.scl_s <= 2'b11;
            q.sda_s <= 2'b11;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.st <= TWD_IDLE;
            q.sdo <= 1'b1;
            q.over_lim <= OVER_RST[15:7]; // RULE21
            q.hyst_lim <= HYST_RST[15:7];
            q.cfg <= CONFIG_RST;
            q.alarm <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // open-drain: drive only a low, release for high
    assign alarm_output_o = 1'b0; // RULE18
    assign alarm_output_oe_n_o = q.alarm;
    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe_n = q.sdo;
    assign config_o = q.cfg;
endmodule // twl_device

// ---- core/twl_ctrl.sv ----
// module: controller end that runs register transfers over the serial link
`timescale 1ns/100ps
module twl_ctrl
    import twl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    twl_if.ctl link,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o
);
    import twl_pkg::*;

    typedef enum logic [2:0] {
        TWC_IDLE = 3'b000,
        TWC_START = 3'b001,
        TWC_BITS = 3'b011,
        TWC_STOP = 3'b010,
        TWC_END = 3'b110
    } twc_state_e;

    typedef struct packed {
        twc_state_e st;
        logic [7:0] div;
        logic [7:0] tick;
        logic [1:0] ph;
        logic [5:0] bitn;
        logic [44:0] tx;
        logic [15:0] rx;
        logic [15:0] result;
        logic [1:0] sel;
        logic wr;
        logic one;
        logic [15:0] wdat;
        logic scl;
        logic sdo;
        logic [1:0] sda_s;
        logic [15:0] rdata;
    } twc_s;

    twc_s q, d;
    logic [5:0] nbits;

    // frame length: addr+sel (18), for reads a re-start slot (1) and addr (9), then data bytes
    always_comb begin
        d = q;
        d.sda_s = {q.sda_s[0], link.sda};
        if (q.wr) nbits = (q.sel == SEL_CONFIG) ? 6'h1B : 6'h24;
        else nbits = q.one ? 6'h25 : 6'h2E;
        // -------------------------------------------------------------
        // software port
        // -------------------------------------------------------------
        if (wr_i && addr_i == CMD_WDATA) d.wdat = wdata_i;
        if (wr_i && addr_i == CMD_DIV) d.div = wdata_i[7:0];
        if (wr_i && addr_i == CMD_CTRL && wdata_i[0] && q.st == TWC_IDLE) begin
            d.wr = wdata_i[1];
            d.sel = wdata_i[3:2];
            d.one = wdata_i[4];
            d.st = TWC_START;
            d.tick = 8'h00;
            d.ph = 2'h0;
        end
        d.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                CMD_STATUS: d.rdata = {15'h0000, q.st != TWC_IDLE};
                CMD_RDATA: d.rdata = q.result;
                CMD_DIV: d.rdata = {8'h00, q.div};
                default: d.rdata = 16'h0000;
            endcase
        end
        // -------------------------------------------------------------
        // link sequencer; scl derived by divider
        // -------------------------------------------------------------
        // phase counter is cleared when a command starts a frame, so a frame never
        // starts in a stale phase
        if (q.st != TWC_IDLE) d.tick = q.tick + 8'h01;
        case (q.st)
            TWC_IDLE: begin
                d.scl = 1'b1;
                d.sdo = 1'b1;
                if (d.st == TWC_START) begin
                    // address 1001000 write, selector byte; master never acks it
                    // read: one re-start slot, then address 1001000 read
                    d.tx = {8'h90, 1'b1, 6'h00, d.sel, 1'b1,
                        (d.wr ? {d.wdat[15:8], 1'b1, d.wdat[7:0], 1'b1, 9'h000}
                              : {1'b1, 8'h91, 1'b1, 17'h1FFFF})};
                end
            end
            TWC_START: begin
                if (q.tick == q.div) begin
                    d.tick = 8'h00;
                    if (q.ph == 2'h0) d.sdo = 1'b0;
                    else d.scl = 1'b0;
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h1) begin
                        d.st = TWC_BITS;
                        d.bitn = 6'h00;
                        d.ph = 2'h0;
                    end
                end
            end
            TWC_BITS: begin
                if (q.tick == q.div) begin
                    d.tick = 8'h00;
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h0) begin
                        // drive data while scl low; release for device slots
                        d.sdo = q.tx[44];
                        if (!q.wr && q.bitn >= 6'h1C) d.sdo = 1'b1; // RULE4
                        if (!q.wr && q.bitn == 6'h24 && !q.one) d.sdo = 1'b0; // RULE10
                    end else if (q.ph == 2'h1) begin
                        d.scl = 1'b1;
                    end else if (q.ph == 2'h2 && !q.wr && q.bitn == 6'h12) begin
                        // re-start: sda falls while scl stays high one more phase
                        d.sdo = 1'b0;
                    end else begin
                        d.scl = 1'b0;
                        d.ph = 2'h0;
                        d.tx = {q.tx[43:0], 1'b1};
                        if (!q.wr && q.bitn >= 6'h1C && q.bitn != 6'h24 && q.bitn != 6'h2D) begin
                            d.rx = {q.rx[14:0], q.sda_s[1]}; // RULE6 RULE7
                        end
                        d.bitn = q.bitn + 6'h01;
                        if (q.bitn == nbits - 6'h01) begin
                            d.st = TWC_STOP;
                            d.sdo = 1'b0;
                        end
                    end
                end
            end
            TWC_STOP: begin
                if (q.tick == q.div) begin
                    d.tick = 8'h00;
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h0) d.scl = 1'b1;
                    else begin
                        d.sdo = 1'b1;
                        d.st = TWC_END;
                        d.result = q.one ? {q.rx[7:0], 8'h00} : q.rx;
                    end
                end
            end
            TWC_END: d.st = TWC_IDLE;
            default: d.st = TWC_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            q <= '0;
            q.st <= TWC_IDLE;
            q.div <= DIV_RST;
            q.scl <= 1'b1;
            q.sdo <= 1'b1;
            q.sda_s <= 2'b11;
        end else begin
            q <= d;
        end
    end

    assign link.scl = q.scl;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe_n = q.sdo;
    assign rdata_o = q.rdata;
endmodule // twl_ctrl

// ---- testbench/twl_link_monitor.sv ----
// checker: drive and framing rules seen on the shared serial link
`timescale 1ns/100ps
module twl_link_monitor (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_o,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_o,
    input wire logic sda_s_oe_n
);
    logic scl_p_q;
    logic sda_p_q;
    logic [7:0] rise_q;
    logic start_w;
    logic stop_w;
    // start and stop are sda edges while scl stays high
    assign start_w = scl && scl_p_q && sda_p_q && !sda;
    assign stop_w = scl && scl_p_q && !sda_p_q && sda;
    // scl rises since the last start; a repeated start restarts the count
    always_ff @(posedge clk_sys_i) begin
        scl_p_q <= scl;
        sda_p_q <= sda;
        if (srst_i || start_w) begin
            rise_q <= 8'h00;
        end else if (scl && !scl_p_q && rise_q != 8'hFF) begin
            rise_q <= rise_q + 8'h01;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    dev_open_drain_a: assert property (!sda_s_oe_n |-> !sda_s_o)
        else $error("device drives sda high");
    ctl_open_drain_a: assert property (!sda_m_oe_n |-> !sda_m_o)
        else $error("controller drives sda high");
    dev_scl_low_a: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("device changed sda while scl high");
    reset_idle_a: assert property ($fell(srst_i) |-> scl && sda_m_oe_n && sda_s_oe_n)
        else $error("link not idle after reset");
    scl_high_len_a: assert property ($rose(scl) |=> scl [*7])
        else $error("scl high phase too short");
    scl_low_len_a: assert property ($fell(scl) |=> !scl [*7])
        else $error("scl low phase too short");
    frame_ack_a: assert property (start_w |-> ##[1:400] !sda_s_oe_n)
        else $error("device gave no acknowledge after start");
    frame_bits_a: assert property (stop_w |-> rise_q % 9 == 1 && rise_q >= 8'd19)
        else $error("frame stopped inside a byte");
endmodule // twl_link_monitor

// ---- testbench/thermal_watch_logic_test.sv ----
// testbench: both link ends joined, driven through the controller register port
`timescale 1ns/100ps
module thermal_watch_logic_test;
    import twl_pkg::*;
    localparam int CONV = 16;
    localparam logic [10:0] HOT = 11'h0F0;
    localparam logic [10:0] MID = 11'h0B0;
    localparam logic [10:0] COLD = 11'h078;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [10:0] adc_q = 11'h000;
    logic [3:0] addr_q = 4'h0;
    logic [15:0] wdata_q = 16'h0000;
    logic wr_q = 1'b0;
    logic rd_q = 1'b0;
    logic [15:0] rdata_w;
    logic alarm_w;
    logic alarm_oe_n_w;
    logic [7:0] config_w;
    logic [15:0] got;
    logic [10:0] tv [2] = '{11'h649, 11'h3F7};
    int qn [4] = '{1, 2, 4, 6};
    int n_errors = 0;
    int cmp_count = 0;
    twl_if link_if ();
    twl_device #(.CONV_PERIOD(CONV)) twl_device_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .link(link_if), .adc_result_i(adc_q), .alarm_output_o(alarm_w),
        .alarm_output_oe_n_o(alarm_oe_n_w), .config_o(config_w));
    twl_ctrl twl_ctrl_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link_if),
        .addr_i(addr_q), .wdata_i(wdata_q), .wr_i(wr_q), .rd_i(rd_q), .rdata_o(rdata_w));
    twl_link_monitor twl_link_monitor_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .scl(link_if.scl), .sda(link_if.sda), .sda_m_o(link_if.sda_m_o),
        .sda_m_oe_n(link_if.sda_m_oe_n), .sda_s_o(link_if.sda_s_o),
        .sda_s_oe_n(link_if.sda_s_oe_n));
    // free-running system clock
    always #4 clk_sys_i = ~clk_sys_i;
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
        cmp_count++;
        if (exp !== act) begin
            $display("BAD %s expected %h seen %h", what, exp, act);
            n_errors++;
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_q <= a;
        wdata_q <= d;
        wr_q <= 1'b1;
        @(posedge clk_sys_i);
        wr_q <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        addr_q <= a;
        rd_q <= 1'b1;
        @(posedge clk_sys_i);
        rd_q <= 1'b0;
        #1;
        d = rdata_w;
    endtask
    // one link transfer, polling busy under a bound; result lands in got
    task automatic xfer(input logic wr, input logic [1:0] sel, input logic one,
                        input logic [15:0] d);
        int n = 0;
        logic [15:0] st = 16'h0001;
        if (wr) bus_wr(CMD_WDATA, d);
        bus_wr(CMD_CTRL, {11'h000, one, sel, wr, 1'b1});
        while (st[0] !== 1'b0 && n < 3000) begin
            bus_rd(CMD_STATUS, st);
            n++;
        end
        chk("busy", 16'h0000, {15'h0000, st[0]});
        bus_rd(CMD_RDATA, got);
    endtask
    task automatic hold(input logic [10:0] v, input int n);
        @(posedge clk_sys_i);
        adc_q <= v;
        repeat (n) @(posedge clk_sys_i);
    endtask
    // pin level equals the drive enable; the data side must stay at zero
    task automatic pin(input logic lvl);
        #1;
        chk("alarm pin", {15'h0000, lvl}, {15'h0000, alarm_oe_n_w});
        chk("alarm data", 16'h0000, {15'h0000, alarm_w});
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog, well beyond the expected run length
    initial begin
        repeat (95000) @(posedge clk_sys_i);
        n_errors++;
        test_done();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        xfer(0, SEL_OVER, 0, 16'h0000);
        chk("over limit", OVER_RST, got);
        xfer(0, SEL_HYST, 0, 16'h0000);
        chk("hyst limit", HYST_RST, got);
        bus_rd(CMD_DIV, got);
        chk("divider", {8'h00, DIV_RST}, got);
        bus_rd(4'hF, got);
        chk("unmapped", 16'h0000, got);
        chk("config", {8'h00, CONFIG_RST}, {8'h00, config_w});
        pin(1'b1);
        $display("test reset done");
        foreach (tv[i]) begin
            hold(tv[i], 40);
            xfer(0, SEL_READING, 0, 16'h0000);
            chk("reading", {tv[i], 5'h00}, got);
            xfer(0, SEL_READING, 1, 16'h0000);
            chk("reading high", {8'h00, tv[i][10:3]}, {8'h00, got[15:8]});
        end
        xfer(1, SEL_READING, 0, 16'hFFFF);
        xfer(0, SEL_READING, 0, 16'h0000);
        chk("read only", {tv[1], 5'h00}, got);
        xfer(1, SEL_OVER, 0, 16'h7DFF);
        xfer(0, SEL_OVER, 0, 16'h0000);
        chk("over write", 16'h7D80, got);
        xfer(1, SEL_HYST, 0, 16'hE4FF);
        xfer(0, SEL_HYST, 0, 16'h0000);
        chk("hyst write", 16'hE480, got);
        $display("test registers done");
        // limits 25.0 and 20.0 degrees, over kept above hyst
        xfer(1, SEL_OVER, 0, 16'h1900);
        xfer(1, SEL_HYST, 0, 16'h1400);
        hold(HOT, 40);
        pin(1'b0);
        xfer(0, SEL_READING, 0, 16'h0000);
        pin(1'b0);
        xfer(1, SEL_CONFIG, 0, 16'h0100);
        pin(1'b0);
        xfer(1, SEL_CONFIG, 0, 16'h0000);
        hold(MID, 40);
        pin(1'b0);
        hold(COLD, 40);
        pin(1'b1);
        xfer(1, SEL_CONFIG, 0, 16'h0400);
        chk("config", 16'h0004, {8'h00, config_w});
        pin(1'b0);
        hold(HOT, 40);
        pin(1'b1);
        xfer(1, SEL_CONFIG, 0, 16'h0000);
        hold(COLD, 40);
        $display("test comparator done");
        // a hot run one conversion short of the queue must not trip the alarm
        foreach (qn[i]) begin
            xfer(1, SEL_CONFIG, 0, {3'h0, 2'(i), 3'h0, 8'h00});
            if (qn[i] > 1) hold(HOT, qn[i] * CONV - CONV - 8);
            hold(COLD, 40);
            pin(1'b1);
            hold(HOT, qn[i] * CONV + 8);
            pin(1'b0);
            hold(COLD, 6 * CONV + 40);
        end
        $display("test fault queue done");
        xfer(1, SEL_CONFIG, 0, 16'h0000);
        hold(MID, 40);
        xfer(1, SEL_CONFIG, 0, 16'h0200);
        chk("config", 16'h0002, {8'h00, config_w});
        hold(HOT, 40);
        pin(1'b0);
        xfer(0, SEL_HYST, 0, 16'h0000);
        pin(1'b1);
        hold(HOT, 60);
        pin(1'b1);
        hold(COLD, 40);
        pin(1'b0);
        xfer(0, SEL_OVER, 0, 16'h0000);
        pin(1'b1);
        hold(HOT, 40);
        pin(1'b0);
        xfer(1, SEL_CONFIG, 0, 16'h0300);
        pin(1'b1);
        hold(11'h111, 60);
        xfer(0, SEL_READING, 0, 16'h0000);
        chk("frozen reading", {HOT, 5'h00}, got);
        $display("test interrupt done");
        test_done();
    end
endmodule // thermal_watch_logic_test
